// ==== inc/screen_pkg.sv ====
package screen_pkg;

  localparam int CLK_HZ = 40_000_000;
  localparam int CLK_KHZ = CLK_HZ / 1000;

  // Times in milliseconds and the cycle counts derived from them.
  localparam int RESET_MIN_MS = 250;
  localparam int RESET_MAX_MS = 2000;
  localparam int LAMP_TEST_MS = 1000;
  localparam int SCAN_SHOW_MS = 1000;
  localparam int FLASH_STEP_MS = 125;
  localparam int RESET_MIN_CYC = RESET_MIN_MS * CLK_KHZ;
  localparam int RESET_MAX_CYC = RESET_MAX_MS * CLK_KHZ;
  localparam int LAMP_TEST_CYC = LAMP_TEST_MS * CLK_KHZ;
  localparam int SCAN_SHOW_CYC = SCAN_SHOW_MS * CLK_KHZ;
  localparam int FLASH_STEP_CYC = FLASH_STEP_MS * CLK_KHZ;

  localparam int NUM_ZONES = 8;
  localparam int DEFAULT_BEAMS = 16;
  localparam int ADDR_W = 8;

  // Register byte addresses.
  localparam logic [7:0] CONFIG_OFFSET = 8'h00;
  localparam logic [7:0] STATE_OFFSET = 8'h04;
  localparam logic [7:0] EVENT_OFFSET = 8'h08;
  localparam logic [7:0] MASK_OFFSET = 8'h0c;

  // Configuration fields.
  localparam int CFG_LATCH_BIT = 0;
  localparam int CFG_EDM_LSB = 1;
  localparam int CFG_RR_BIT = 3;
  localparam int CFG_SCAN_BIT = 4;
  localparam logic [4:0] CONFIG_RESET = 5'h04;

  // Monitoring modes.
  localparam logic [1:0] EDM_NONE = 2'h0;
  localparam logic [1:0] EDM_ONE = 2'h1;
  localparam logic [1:0] EDM_TWO = 2'h2;

  // Event bits.
  localparam int EV_LOCKOUT = 0;
  localparam int EV_TRIP = 1;
  localparam int EV_RESET = 2;
  localparam int EV_SYNC = 3;
  localparam int NUM_EVENTS = 4;

  typedef enum logic [2:0] {
    ST_LAMP_TEST = 3'h0,
    ST_SCAN_SHOW = 3'h1,
    ST_LOCKOUT = 3'h2,
    ST_LATCHED = 3'h3,
    ST_BLOCKED = 3'h4,
    ST_CLEAR_RUN = 3'h5
  } screen_state_type;

  typedef enum logic [2:0] {
    DISP_OFF = 3'h0,
    DISP_ALL = 3'h1,
    DISP_SCAN = 3'h2,
    DISP_COUNT = 3'h3,
    DISP_CH1 = 3'h4,
    DISP_FAULT = 3'h5
  } display_mode_type;

endpackage : screen_pkg

// ==== inc/reset_qual_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface reset_qual_if;
  logic switch_closed;
  logic reset_valid;
  modport qual (input switch_closed, output reset_valid);
  modport user (output switch_closed, input reset_valid);
endinterface : reset_qual_if
`default_nettype wire

// ==== rtl/reset_qualifier.sv ====
`timescale 1ns/10ps
`default_nettype none
module reset_qualifier
  import screen_pkg::*;
#(
  parameter int MIN_CYCLES = RESET_MIN_CYC,
  parameter int MAX_CYCLES = RESET_MAX_CYC
) (
  input wire logic core_clk,
  input wire logic resetn,
  reset_qual_if.qual rq
);
  localparam int CW = $clog2(MAX_CYCLES + 2);
  localparam logic [CW-1:0] MIN_C = CW'(MIN_CYCLES);
  localparam logic [CW-1:0] MAX_C = CW'(MAX_CYCLES);

  logic [CW-1:0] held_q;
  logic closed_q;
  logic valid_q;

  // Measures how long the switch is held and saturates past the upper limit.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      held_q <= '0;
      closed_q <= 1'b0;
    end else begin
      closed_q <= rq.switch_closed;
      if (!rq.switch_closed) begin
        held_q <= '0;
      end else if (held_q <= MAX_C) begin
        held_q <= held_q + 1'b1;
      end
    end
  end

  // A release after a hold within the window gives one valid pulse.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= closed_q && !rq.switch_closed && held_q >= MIN_C && held_q <= MAX_C; // see R1
    end
  end

  assign rq.reset_valid = valid_q;

endmodule : reset_qualifier
`default_nettype wire

// ==== rtl/light_screen_status.sv ====
// How it works
// R1: Reset accepted after quarter-second hold, under two seconds.
// R2: Defaults: trip, two-channel monitoring, no reduction, code one.
// R3: Lockout single-flashes status red, zone and reset dark.
// R4: Emitter status steady green in normal operation.
// R5: Open test input flashes emitter status green.
// R6: Latched clear: status red, reset double-flash, zones green.
// R7: Latch mode: outputs on after clear and reset.
// R8: Clear run: green or flashing, reset steady, zones green.
// R9: Blocked: red, reset on, red zones, count shown.
// R10: Sync beam blocked: zone one red, others off.
// R11: Test open: beams minus one shown, zones red.
// R12: Power-up flashes all lamps, then shows scan code.
// R13: Channel one unaligned: red, code shown, zone one red, others dark.
// R14: Unblocked beams turn zones green, count drops.
// R15: Trip mode: outputs off while blocked, self-recovering.
// R16: Outputs off whenever receiver status shows red.
// R17: Valid reset in latch clear enters clear run.
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module light_screen_status
  import screen_pkg::*;
#(
  parameter int NUM_BEAMS = DEFAULT_BEAMS,
  parameter int RESET_MIN_CYCLES = RESET_MIN_CYC,
  parameter int RESET_MAX_CYCLES = RESET_MAX_CYC,
  parameter int LAMP_TEST_CYCLES = LAMP_TEST_CYC,
  parameter int SCAN_SHOW_CYCLES = SCAN_SHOW_CYC,
  parameter int FLASH_STEP_CYCLES = FLASH_STEP_CYC
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  output logic irq,
  input wire logic [NUM_BEAMS-1:0] beam_blocked,
  input wire logic emitter_has_test,
  input wire logic test_input_open,
  input wire logic reset_switch_closed,
  input wire logic receiver_fault,
  input wire logic emitter_fault,
  input wire logic [1:0] external_device_monitoring,
  output logic [1:0] safety_switching_output,
  output logic emitter_status_red,
  output logic emitter_status_green,
  output logic status_red,
  output logic status_green,
  output logic reset_lamp,
  output logic [NUM_ZONES-1:0] zone_red,
  output logic [NUM_ZONES-1:0] zone_green,
  output display_mode_type display_mode,
  output logic [9:0] display_value
);
  localparam int CNT_W = $clog2(NUM_BEAMS + 1);
  localparam int BEAMS_PER_ZONE = (NUM_BEAMS + NUM_ZONES - 1) / NUM_ZONES;
  localparam int TMR_W = $clog2(LAMP_TEST_CYCLES + SCAN_SHOW_CYCLES + FLASH_STEP_CYCLES + 2);

  reset_qual_if rq ();

  screen_state_type state_q;
  logic [4:0] config_q;
  logic [NUM_EVENTS-1:0] event_q;
  logic [NUM_EVENTS-1:0] mask_q;
  logic [TMR_W-1:0] timer_q;
  logic [TMR_W-1:0] step_q;
  logic [2:0] phase_q;
  logic step_tick;
  logic sync_lost_q;
  logic [CNT_W-1:0] blocked_count;
  logic [NUM_ZONES-1:0] zone_blocked;
  logic rr_tolerated;
  logic sync_blocked;
  logic trip_cond;
  logic edm_fault;
  logic latch_mode;
  logic single_flash;
  logic double_flash;
  logic [NUM_EVENTS-1:0] events;

  assign rq.switch_closed = reset_switch_closed;

  reset_qualifier #(
    .MIN_CYCLES(RESET_MIN_CYCLES),
    .MAX_CYCLES(RESET_MAX_CYCLES)
  ) u_reset_qualifier (
    .core_clk(core_clk),
    .resetn(resetn),
    .rq(rq)
  );

  assign latch_mode = config_q[CFG_LATCH_BIT];
  assign sync_blocked = beam_blocked[0];

  // Counts blocked beams, maps them to zones and checks the reduced-resolution window.
  always_comb begin
    logic [CNT_W-1:0] n;
    logic adjacent;
    n = '0;
    adjacent = 1'b0;
    zone_blocked = '0;
    for (int b = 0; b < NUM_BEAMS; b++) begin
      if (beam_blocked[b]) begin
        n = n + 1'b1;
        zone_blocked[b / BEAMS_PER_ZONE] = 1'b1; // see R9
      end
      if (b > 1 && beam_blocked[b] && beam_blocked[b-1]) begin
        adjacent = 1'b1;
      end
    end
    blocked_count = n; // see R14
    rr_tolerated = config_q[CFG_RR_BIT] && !sync_blocked && (n < CNT_W'(2) || (n == CNT_W'(2) && adjacent));
  end

  assign trip_cond = (emitter_has_test && test_input_open) || sync_blocked || (blocked_count != '0 && !rr_tolerated);

  // Monitored contactors must read released while the outputs are off.
  always_comb begin
    edm_fault = 1'b0;
    if (state_q != ST_CLEAR_RUN && step_tick) begin
      case (config_q[CFG_EDM_LSB +: 2])
        EDM_ONE: edm_fault = !external_device_monitoring[0];
        EDM_TWO: edm_fault = external_device_monitoring != 2'h3;
        default: edm_fault = 1'b0;
      endcase
    end
  end

  // Step divider for the flash patterns.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      step_q <= '0;
      phase_q <= '0;
    end else if (step_tick) begin
      step_q <= '0;
      phase_q <= phase_q + 1'b1;
    end else begin
      step_q <= step_q + 1'b1;
    end
  end

  assign step_tick = step_q == TMR_W'(FLASH_STEP_CYCLES - 1);
  assign single_flash = !phase_q[2];
  assign double_flash = phase_q == 3'h0 || phase_q == 3'h2;

  // Operating state of the receiver.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_q <= ST_LAMP_TEST;
      timer_q <= TMR_W'(LAMP_TEST_CYCLES - 1);
    end else if ((receiver_fault || edm_fault) && state_q != ST_LOCKOUT) begin
      state_q <= ST_LOCKOUT; // see R3
    end else begin
      if (timer_q != '0) begin
        timer_q <= timer_q - 1'b1;
      end
      case (state_q)
        ST_LAMP_TEST: begin
          if (timer_q == '0) begin
            state_q <= ST_SCAN_SHOW; // see R12
            timer_q <= TMR_W'(SCAN_SHOW_CYCLES - 1);
          end
        end
        ST_SCAN_SHOW: begin
          if (timer_q == '0) begin
            state_q <= latch_mode ? ST_LATCHED : ST_BLOCKED;
          end
        end
        ST_LOCKOUT: begin
          if (rq.reset_valid && !receiver_fault) begin
            state_q <= latch_mode ? ST_LATCHED : ST_BLOCKED;
          end
        end
        ST_LATCHED: begin
          if (trip_cond) begin
            state_q <= ST_BLOCKED;
          end else if (rq.reset_valid) begin
            state_q <= ST_CLEAR_RUN; // see R7 see R17
          end
        end
        ST_BLOCKED: begin
          if (!trip_cond) begin
            state_q <= latch_mode ? ST_LATCHED : ST_CLEAR_RUN; // see R15
          end
        end
        ST_CLEAR_RUN: begin
          if (trip_cond) begin
            state_q <= ST_BLOCKED; // see R15
          end
        end
        default: state_q <= ST_LOCKOUT;
      endcase
    end
  end

  // Outputs conduct only in clear run, never while status shows red.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      safety_switching_output <= 2'h0;
    end else if (state_q == ST_CLEAR_RUN && !trip_cond) begin
      safety_switching_output <= 2'h3; // see R16
    end else begin
      safety_switching_output <= 2'h0; // see R16
    end
  end

  // Emitter lamp.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      emitter_status_red <= 1'b0;
      emitter_status_green <= 1'b0;
    end else if (state_q == ST_LAMP_TEST) begin
      emitter_status_red <= single_flash;
      emitter_status_green <= single_flash;
    end else if (emitter_fault) begin
      emitter_status_red <= single_flash; // see R3
      emitter_status_green <= 1'b0;
    end else if (emitter_has_test && test_input_open) begin
      emitter_status_red <= 1'b0;
      emitter_status_green <= single_flash; // see R5
    end else begin
      emitter_status_red <= 1'b0;
      emitter_status_green <= 1'b1; // see R4
    end
  end

  // Receiver lamps and display.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      status_red <= 1'b0;
      status_green <= 1'b0;
      reset_lamp <= 1'b0;
      zone_red <= '0;
      zone_green <= '0;
      display_mode <= DISP_OFF;
      display_value <= '0;
    end else begin
      status_red <= 1'b0;
      status_green <= 1'b0;
      reset_lamp <= 1'b0;
      zone_red <= '0;
      zone_green <= '0;
      display_mode <= DISP_OFF;
      display_value <= '0;
      case (state_q)
        ST_LAMP_TEST: begin
          status_red <= single_flash; // see R12
          status_green <= single_flash;
          reset_lamp <= single_flash;
          zone_red <= {NUM_ZONES{single_flash}};
          zone_green <= {NUM_ZONES{single_flash}};
          display_mode <= single_flash ? DISP_ALL : DISP_OFF;
        end
        ST_SCAN_SHOW: begin
          display_mode <= DISP_SCAN; // see R12
          display_value <= 10'(config_q[CFG_SCAN_BIT]) + 10'h1;
        end
        ST_LOCKOUT: begin
          status_red <= single_flash; // see R3
          display_mode <= DISP_FAULT;
        end
        ST_LATCHED: begin
          status_red <= 1'b1; // see R6
          reset_lamp <= double_flash;
          zone_green <= '1;
        end
        ST_BLOCKED: begin
          status_red <= 1'b1; // see R9
          reset_lamp <= 1'b1;
          if (emitter_has_test && test_input_open) begin
            zone_red <= '1; // see R11
            if (NUM_BEAMS == 10) begin
              zone_red[0] <= 1'b0;
              zone_green[0] <= 1'b1;
            end
            display_mode <= DISP_COUNT;
            display_value <= 10'(NUM_BEAMS - 1);
          end else if (sync_blocked) begin
            zone_red[0] <= 1'b1; // see R10 see R13
            display_mode <= DISP_CH1;
          end else begin
            zone_red <= zone_blocked; // see R9 see R14
            zone_green <= ~zone_blocked;
            display_mode <= DISP_COUNT;
            display_value <= 10'(blocked_count);
          end
        end
        ST_CLEAR_RUN: begin
          status_green <= config_q[CFG_RR_BIT] ? single_flash : 1'b1; // see R8
          reset_lamp <= 1'b1;
          zone_green <= '1;
        end
        default: display_mode <= DISP_FAULT;
      endcase
    end
  end

  // Events for the interrupt status.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sync_lost_q <= 1'b0;
    end else begin
      sync_lost_q <= sync_blocked;
    end
  end

  always_comb begin
    events = '0;
    events[EV_LOCKOUT] = state_q != ST_LOCKOUT && (receiver_fault || edm_fault);
    events[EV_TRIP] = state_q == ST_CLEAR_RUN && trip_cond;
    events[EV_RESET] = rq.reset_valid;
    events[EV_SYNC] = sync_blocked && !sync_lost_q;
  end

  // Configuration and mask registers.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      config_q <= CONFIG_RESET; // see R2
      mask_q <= '0;
    end else if (reg_write) begin
      if (reg_addr == CONFIG_OFFSET) begin
        config_q <= reg_wdata[4:0];
      end
      if (reg_addr == MASK_OFFSET) begin
        mask_q <= reg_wdata[NUM_EVENTS-1:0];
      end
    end
  end

  // Sticky events; a new event wins over a write-one clear.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      event_q <= '0;
    end else if (reg_write && reg_addr == EVENT_OFFSET) begin
      event_q <= (event_q & ~reg_wdata[NUM_EVENTS-1:0]) | events;
    end else begin
      event_q <= event_q | events;
    end
  end

  assign irq = |(event_q & mask_q);

  // Read data stand in the cycle after the strobe only.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      reg_rdata <= '0;
    end else if (reg_read) begin
      case (reg_addr)
        CONFIG_OFFSET: reg_rdata <= {27'h0, config_q};
        STATE_OFFSET: reg_rdata <= {14'h0, safety_switching_output, 8'(blocked_count), 5'h0, state_q};
        EVENT_OFFSET: reg_rdata <= {28'h0, event_q};
        MASK_OFFSET: reg_rdata <= {28'h0, mask_q};
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule : light_screen_status
`default_nettype wire

// ==== sim/machine_ctrl_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module machine_ctrl_model #(
  parameter int LAG = 0
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [1:0] safety_switching_output,
  output logic [1:0] external_device_monitoring
);
  // The contactors report released while the outputs are off, after LAG cycles.
  logic [15:0] pipe_q;
  logic [17:0] chain;
  assign chain = {pipe_q, ~safety_switching_output};
  assign external_device_monitoring = chain[2*LAG+1 -: 2];
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pipe_q <= 16'hffff;
    end else begin
      pipe_q <= chain[15:0];
    end
  end
endmodule : machine_ctrl_model
`default_nettype wire

// ==== sim/screen_chk.sv ====
`timescale 1ns/10ps
`default_nettype none
module screen_chk
  import screen_pkg::*;
#(
  parameter int NUM_BEAMS = DEFAULT_BEAMS,
  parameter int LAMP_TEST_CYCLES = LAMP_TEST_CYC,
  parameter int SCAN_SHOW_CYCLES = SCAN_SHOW_CYC
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic [NUM_BEAMS-1:0] beam_blocked,
  input wire logic emitter_has_test,
  input wire logic test_input_open,
  input wire logic [1:0] safety_switching_output,
  input wire logic status_red,
  input wire logic reset_lamp,
  input wire display_mode_type display_mode,
  input wire logic [9:0] display_value
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // Cycles since reset release, saturating.
  logic [15:0] up_q;
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      up_q <= 16'h0;
    end else if (up_q != 16'hffff) begin
      up_q <= up_q + 16'h1;
    end
  end
  sequence s_test_open;
    (emitter_has_test && test_input_open) [*3];
  endsequence
  property p_red_off;
    status_red |-> safety_switching_output == 2'h0;
  endproperty
  a_red_off: assert property (p_red_off) else $error("outputs on with status red");
  property p_pair;
    safety_switching_output[0] == safety_switching_output[1];
  endproperty
  a_pair: assert property (p_pair) else $error("output channels differ");
  property p_sync_trip;
    beam_blocked[0] |-> ##[1:3] safety_switching_output == 2'h0;
  endproperty
  a_sync_trip: assert property (p_sync_trip) else $error("outputs on with sync beam blocked");
  property p_test_off;
    s_test_open |-> ##1 safety_switching_output == 2'h0;
  endproperty
  a_test_off: assert property (p_test_off) else $error("outputs on with test open");
  property p_rise_clear;
    $rose(safety_switching_output[0]) |-> $past(beam_blocked[0], 2) == 1'b0;
  endproperty
  a_rise_clear: assert property (p_rise_clear) else $error("outputs rose with sync blocked");
  property p_on_lamp;
    safety_switching_output != 2'h0 |-> reset_lamp;
  endproperty
  a_on_lamp: assert property (p_on_lamp) else $error("reset lamp dark in run");
  property p_powerup;
    up_q < LAMP_TEST_CYCLES + SCAN_SHOW_CYCLES |-> safety_switching_output == 2'h0;
  endproperty
  a_powerup: assert property (p_powerup) else $error("outputs on during power-up");
  property p_lamp_test;
    up_q >= 16'h2 && up_q < LAMP_TEST_CYCLES - 1 |-> display_mode == DISP_ALL;
  endproperty
  a_lamp_test: assert property (p_lamp_test) else $error("no lamp test");
  property p_scan;
    up_q == LAMP_TEST_CYCLES + 3 |-> display_mode == DISP_SCAN && display_value == 10'h1;
  endproperty
  a_scan: assert property (p_scan) else $error("scan code not shown");
  property p_rdata;
    !$past(reg_read) |-> reg_rdata == 32'h0;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside its cycle");
endmodule : screen_chk
bind light_screen_status screen_chk #(.NUM_BEAMS(NUM_BEAMS), .LAMP_TEST_CYCLES(LAMP_TEST_CYCLES),
  .SCAN_SHOW_CYCLES(SCAN_SHOW_CYCLES)) i_chk (.core_clk, .resetn, .reg_read, .reg_rdata, .beam_blocked,
  .emitter_has_test, .test_input_open, .safety_switching_output, .status_red, .reset_lamp, .display_mode,
  .display_value);
`default_nettype wire

// ==== sim/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb;
  import screen_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0, reg_read = 1'b0, irq;
  logic [31:0] reg_rdata;
  logic [15:0] beam_blocked = 16'h0;
  logic emitter_has_test = 1'b1, test_input_open = 1'b0, reset_switch_closed = 1'b0;
  logic receiver_fault = 1'b0, emitter_fault = 1'b0;
  logic [1:0] external_device_monitoring, safety_switching_output;
  logic emitter_status_red, emitter_status_green, status_red, status_green, reset_lamp;
  logic [7:0] zone_red, zone_green;
  display_mode_type display_mode;
  logic [9:0] display_value;
  int fail_count = 0, n_tests = 0, cyc = 0;
  int tog [5];
  light_screen_status #(.RESET_MIN_CYCLES(20), .RESET_MAX_CYCLES(100), .LAMP_TEST_CYCLES(10),
    .SCAN_SHOW_CYCLES(10), .FLASH_STEP_CYCLES(4)) i_dut (.core_clk, .resetn, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .irq, .beam_blocked, .emitter_has_test, .test_input_open,
    .reset_switch_closed, .receiver_fault, .emitter_fault, .external_device_monitoring,
    .safety_switching_output, .emitter_status_red, .emitter_status_green, .status_red, .status_green,
    .reset_lamp, .zone_red, .zone_green, .display_mode, .display_value);
  machine_ctrl_model i_mc (.core_clk, .resetn, .safety_switching_output, .external_device_monitoring);
  always #12.5 core_clk = ~core_clk;
  task stop_test;
    $display("Checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      stop_test();
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata, e, nm);
  endtask : rd
  task beams(input logic [15:0] b);
    @(posedge core_clk);
    beam_blocked <= b;
  endtask : beams
  task press(input int n);
    @(posedge core_clk);
    reset_switch_closed <= 1'b1;
    repeat (n) @(posedge core_clk);
    reset_switch_closed <= 1'b0;
    step(6);
  endtask : press
  task wait_out(input logic [1:0] v);
    for (int i = 0; i < 300 && safety_switching_output !== v; i++) step(1);
    chk(safety_switching_output, v, "outputs");
  endtask : wait_out
  // Counts lamp changes over 40 cycles, one and a quarter flash periods.
  task watch;
    logic [4:0] p, c;
    tog = '{0, 0, 0, 0, 0};
    p = {status_red, reset_lamp, emitter_status_red, status_green, emitter_status_green};
    repeat (40) begin
      step(1);
      c = {status_red, reset_lamp, emitter_status_red, status_green, emitter_status_green};
      for (int k = 0; k < 5; k++) if (c[k] !== p[k]) tog[k]++;
      p = c;
    end
  endtask : watch
  initial begin
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    step(3);
    chk(display_mode, DISP_ALL, "display");
    rd(CONFIG_OFFSET, 32'h4, "config");
    rd(STATE_OFFSET, 32'h0, "state");
    rd(8'h10, 32'h0, "unmapped");
    step(6);
    chk(display_mode, DISP_SCAN, "display");
    chk(display_value, 32'h1, "scan code");
    wait_out(2'h3);
    step(2);
    chk({status_green, reset_lamp, zone_green}, 32'h3ff, "run lamps");
    chk(emitter_status_green, 1'b1, "emitter green");
    $display("Test power-up done");
    beams(16'h0020);
    wait_out(2'h0);
    step(2);
    chk({status_red, reset_lamp, zone_red}, 32'h304, "blocked lamps");
    chk(display_value, 32'h1, "count");
    beams(16'h0030);
    step(3);
    chk(display_value, 32'h2, "count");
    beams(16'h0020);
    step(3);
    chk({zone_green, display_value}, {8'hfb, 10'h1}, "unblock");
    beams(16'h0);
    wait_out(2'h3);
    wr(EVENT_OFFSET, 32'hf);
    wr(MASK_OFFSET, 32'h8);
    step(1);
    chk(irq, 1'b0, "irq");
    beams(16'h1);
    wait_out(2'h0);
    step(2);
    chk({zone_red, zone_green}, 32'h100, "sync zones");
    chk(display_mode, DISP_CH1, "display");
    chk(irq, 1'b1, "irq");
    wr(MASK_OFFSET, 32'h0);
    step(1);
    chk(irq, 1'b0, "irq masked");
    wr(MASK_OFFSET, 32'h8);
    beams(16'h0);
    wr(EVENT_OFFSET, 32'h8);
    step(1);
    chk(irq, 1'b0, "irq cleared");
    wait_out(2'h3);
    $display("Test blocked done");
    @(posedge core_clk);
    test_input_open <= 1'b1;
    wait_out(2'h0);
    watch();
    chk(tog[0] > 0, 1'b1, "test flash");
    chk({zone_red, display_value}, {8'hff, 10'hf}, "test display");
    @(posedge core_clk);
    emitter_has_test <= 1'b0;
    step(4);
    chk({safety_switching_output, emitter_status_green}, 32'h7, "no test input");
    @(posedge core_clk);
    emitter_has_test <= 1'b1;
    test_input_open <= 1'b0;
    wait_out(2'h3);
    wr(CONFIG_OFFSET, 32'hc);
    watch();
    chk(tog[1] > 0, 1'b1, "reduced flash");
    $display("Test modes done");
    wr(CONFIG_OFFSET, 32'h5);
    beams(16'h1);
    wait_out(2'h0);
    beams(16'h0);
    step(6);
    rd(STATE_OFFSET, 32'h3, "state");
    chk({status_red, zone_green}, 32'h1ff, "latch lamps");
    watch();
    chk(tog[3] > 0, 1'b1, "reset flash");
    press(5);
    chk(safety_switching_output, 2'h0, "short press");
    press(120);
    chk(safety_switching_output, 2'h0, "long press");
    press(40);
    wait_out(2'h3);
    chk(status_green, 1'b1, "run after reset");
    $display("Test latch done");
    wr(CONFIG_OFFSET, 32'h4);
    @(posedge core_clk);
    receiver_fault <= 1'b1;
    emitter_fault <= 1'b1;
    wait_out(2'h0);
    step(4);
    watch();
    chk({tog[4] > 0, tog[2] > 0}, 2'h3, "fault flash");
    chk({reset_lamp, zone_red, zone_green}, 32'h0, "fault dark");
    @(posedge core_clk);
    receiver_fault <= 1'b0;
    emitter_fault <= 1'b0;
    press(40);
    wait_out(2'h3);
    rd(EVENT_OFFSET, 32'hf, "events");
    wr(EVENT_OFFSET, 32'hf);
    rd(EVENT_OFFSET, 32'h0, "events cleared");
    $display("Test lockout done");
    stop_test();
  end
endmodule : tb
`default_nettype wire
